// ---- common/dlb_defines.svh ----
`ifndef DLB_DEFINES_SVH
`define DLB_DEFINES_SVH

// Register offsets on the serial port's internal byte bus
`define DLB_ADDR_W          7
`define DLB_ADDR_ACQ_BW     7'h69
`define DLB_ADDR_AUX_DAMP   7'h6A

// Reset values
`define DLB_RST_ACQ_BW      8'h0F
`define DLB_RST_AUX_DAMP    8'h13
`define DLB_RST_DAMPING     3'h3

// Writable bits; the rest read as zero
`define DLB_MASK_ACQ_BW     8'h0F
`define DLB_MASK_AUX_DAMP   8'h77

// Field positions
`define DLB_ACQ_BW_MSB      3
`define DLB_ACQ_BW_LSB      0
`define DLB_GAIN_MSB        6
`define DLB_GAIN_LSB        4
`define DLB_DAMP_MSB        2
`define DLB_DAMP_LSB        0

// Acquisition bandwidth codes
`define DLB_BW_0P3          4'h8
`define DLB_BW_0P6          4'h9
`define DLB_BW_1P2          4'hA
`define DLB_BW_2P5          4'hB
`define DLB_BW_4            4'hC
`define DLB_BW_8            4'hD
`define DLB_BW_18           4'hE
`define DLB_BW_35           4'hF
`define DLB_BW_70           4'h1

// Bandwidths in tenths of a hertz
`define DLB_HZX10_W         10
`define DLB_HZX10_0P3       10'h003
`define DLB_HZX10_0P6       10'h006
`define DLB_HZX10_1P2       10'h00C
`define DLB_HZX10_2P5       10'h019
`define DLB_HZX10_4         10'h028
`define DLB_HZX10_8         10'h050
`define DLB_HZX10_18        10'h0B4
`define DLB_HZX10_35        10'h15E
`define DLB_HZX10_70        10'h2BC
`define DLB_HZX10_NONE      10'h000

`define DLB_GAIN_OFF        3'h0
`define DLB_NIBBLE_ZERO     4'h0
`define DLB_BYTE_ZERO       8'h00

`endif

// ---- common/dlb_pkg.sv ----
`default_nettype none

`include "dlb_defines.svh"

package dlb_pkg;

    typedef logic [3:0] dlb_bw_code_t;

    typedef struct packed {
        logic [`DLB_ADDR_W-1:0] addr;
        logic                   wr;
        logic                   rd;
        logic [7:0]             wdata;
    } dlb_reg_req_s;

    typedef struct packed {
        dlb_bw_code_t           bw_code;
        logic [`DLB_HZX10_W-1:0] bw_hzx10;
        logic                   acq_in_use;
    } dlb_main_cfg_s;

    typedef struct packed {
        logic [2:0]             damping;
        logic [2:0]             gain;
        logic                   gain_apply;
    } dlb_aux_cfg_s;

endpackage

`default_nettype wire

// ---- rtl/dlb_cfg_reg.sv ----
`timescale 1ns/1ps
`default_nettype none

module dlb_cfg_reg #(
    parameter logic [7:0] RST_VAL = 8'h00,
    parameter logic [7:0] MASK    = 8'hFF
) (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       ce,
    // Write side
    input  wire logic       wr_en,
    input  wire logic [7:0] wdata,
    // Stored value
    output logic      [7:0] value
);

    logic [7:0] value_r;
    logic [7:0] value_nxt;

    // Unused bits never store, so they read back as zero
    always_comb begin
        value_nxt = value_r;
        if (ce && wr_en) begin
            value_nxt = wdata & MASK;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            value_r <= RST_VAL;
        end else begin
            value_r <= value_nxt;
        end
    end

    assign value = value_r;

endmodule

`default_nettype wire

// ---- rtl/dlb_loop_cfg.sv ----
`timescale 1ns/1ps
`default_nettype none

`include "dlb_defines.svh"

// What this block does
// R1: Low four bits of acquisition register set main loop bandwidth while acquiring.
// R2: Acquisition codes offer 0.3, 0.6, 1.2, 2.5, 4, 8, 18, 35, 70 Hz.
// R3: Code 0001 selects 70 Hz acquisition bandwidth.
// R4: Software must not write reserved acquisition codes.
// R5: Auto-switch bit picks acquisition bandwidth whenever main loop is unlocked.
// R6: Bits 6:4 of damping register set detector 2 low-rate analog gain.
// R7: Detector 2 gain applies only while the gain-select enable bit is set.
// R8: Codes 1000-1111 ascend 0.3-35 Hz; 0001 is 70 Hz; reset gives 35 Hz.
// R9: Bits 2:0 select auxiliary loop damping, default 011.
module dlb_loop_cfg
    import dlb_pkg::*;
(
    // Clock, reset, enable
    input  wire logic              core_clk,
    input  wire logic              rst_n,
    input  wire logic              ce,
    // Register port from the serial interface
    input  wire dlb_reg_req_s      reg_req,
    output logic [7:0]             reg_rdata,
    output logic                   reg_rvalid,
    // Control bits held in other registers
    input  wire logic              acq_bw_auto_en,
    input  wire logic              aux_gain_sel_en,
    input  wire dlb_bw_code_t      main_locked_bw_code,
    // Loop status
    input  wire logic              main_loop_locked,
    input  wire logic              aux_ref_low_rate,
    input  wire logic              aux_analog_feedback,
    // Loop configuration
    output dlb_main_cfg_s          main_cfg,
    output logic                   acq_code_valid,
    output dlb_aux_cfg_s           aux_cfg
);

    logic [7:0]        acq_reg;
    logic [7:0]        damp_reg;
    dlb_bw_code_t      main_loop_acquire_bandwidth;
    logic [2:0]        aux_loop_detector2_low_rate_gain;
    logic [2:0]        aux_loop_damping_select;

    logic [7:0]        rdata_r,  rdata_nxt;
    logic              rvalid_r, rvalid_nxt;
    dlb_main_cfg_s     main_r,   main_nxt;
    logic              valid_r,  valid_nxt;
    dlb_aux_cfg_s      aux_r,    aux_nxt;
    logic [`DLB_HZX10_W-1:0] acq_hzx10;
    logic              acq_known;

    dlb_cfg_reg #(
        .RST_VAL (`DLB_RST_ACQ_BW),
        .MASK    (`DLB_MASK_ACQ_BW)
    ) u_acq_reg (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .ce       (ce),
        .wr_en    (reg_req.wr && reg_req.addr == `DLB_ADDR_ACQ_BW), // see R1
        .wdata    (reg_req.wdata),
        .value    (acq_reg)
    );

    dlb_cfg_reg #(
        .RST_VAL (`DLB_RST_AUX_DAMP),
        .MASK    (`DLB_MASK_AUX_DAMP)
    ) u_damp_reg (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .ce       (ce),
        .wr_en    (reg_req.wr && reg_req.addr == `DLB_ADDR_AUX_DAMP), // see R9
        .wdata    (reg_req.wdata),
        .value    (damp_reg)
    );

    assign main_loop_acquire_bandwidth      = acq_reg[`DLB_ACQ_BW_MSB:`DLB_ACQ_BW_LSB];
    assign aux_loop_detector2_low_rate_gain = damp_reg[`DLB_GAIN_MSB:`DLB_GAIN_LSB];
    assign aux_loop_damping_select          = damp_reg[`DLB_DAMP_MSB:`DLB_DAMP_LSB];

    // Bandwidth decode; reserved codes flag invalid, software must avoid them
    always_comb begin
        acq_known = 1'b1;
        case (main_loop_acquire_bandwidth)
            `DLB_BW_0P3: acq_hzx10 = `DLB_HZX10_0P3; // see R2
            `DLB_BW_0P6: acq_hzx10 = `DLB_HZX10_0P6; // see R8
            `DLB_BW_1P2: acq_hzx10 = `DLB_HZX10_1P2;
            `DLB_BW_2P5: acq_hzx10 = `DLB_HZX10_2P5;
            `DLB_BW_4:   acq_hzx10 = `DLB_HZX10_4;
            `DLB_BW_8:   acq_hzx10 = `DLB_HZX10_8;
            `DLB_BW_18:  acq_hzx10 = `DLB_HZX10_18;
            `DLB_BW_35:  acq_hzx10 = `DLB_HZX10_35;
            `DLB_BW_70:  acq_hzx10 = `DLB_HZX10_70; // see R3
            default: begin
                acq_hzx10 = `DLB_HZX10_NONE; // see R4
                acq_known = 1'b0;
            end
        endcase
    end

    // Register read port
    always_comb begin
        rdata_nxt  = rdata_r;
        rvalid_nxt = rvalid_r;
        if (ce) begin
            rvalid_nxt = reg_req.rd;
            if (reg_req.rd) begin
                case (reg_req.addr)
                    `DLB_ADDR_ACQ_BW:   rdata_nxt = acq_reg;
                    `DLB_ADDR_AUX_DAMP: rdata_nxt = damp_reg; // see R9
                    default:            rdata_nxt = `DLB_BYTE_ZERO;
                endcase
            end
        end
    end

    // Loop configuration; only the acquisition bandwidth is decoded, locked code passes with zero hzx10
    always_comb begin
        main_nxt  = main_r;
        valid_nxt = valid_r;
        aux_nxt   = aux_r;
        if (ce) begin
            valid_nxt           = acq_known;
            main_nxt.acq_in_use = acq_bw_auto_en && !main_loop_locked; // see R5
            if (acq_bw_auto_en && !main_loop_locked) begin
                main_nxt.bw_code  = main_loop_acquire_bandwidth; // see R1
                main_nxt.bw_hzx10 = acq_hzx10;
            end else begin
                main_nxt.bw_code  = main_locked_bw_code; // see R5
                main_nxt.bw_hzx10 = `DLB_HZX10_NONE;
            end
            aux_nxt.damping    = aux_loop_damping_select; // see R9
            aux_nxt.gain_apply = aux_gain_sel_en && aux_ref_low_rate
                                 && aux_analog_feedback; // see R6
            // Gain reads as zero only while the gain-select enable is clear, not when gain_apply drops for other inputs
            aux_nxt.gain       = aux_gain_sel_en ? aux_loop_detector2_low_rate_gain
                                                 : `DLB_GAIN_OFF; // see R7
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r  <= `DLB_BYTE_ZERO;
            rvalid_r <= 1'b0;
            main_r   <= '{bw_code: `DLB_BW_35, bw_hzx10: `DLB_HZX10_NONE, acq_in_use: 1'b0};
            valid_r  <= 1'b1;
            aux_r    <= '{damping: `DLB_RST_DAMPING, gain: `DLB_GAIN_OFF, gain_apply: 1'b0};
        end else begin
            rdata_r  <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
            main_r   <= main_nxt;
            valid_r  <= valid_nxt;
            aux_r    <= aux_nxt;
        end
    end

    assign reg_rdata      = rdata_r;
    assign reg_rvalid     = rvalid_r;
    assign main_cfg       = main_r;
    assign acq_code_valid = valid_r;
    assign aux_cfg        = aux_r;

    sequence s_wr_acq;
        ce && reg_req.wr && reg_req.addr == `DLB_ADDR_ACQ_BW && !reg_req.rd;
    endsequence

    sequence s_rd_acq;
        ce && reg_req.rd && !reg_req.wr && reg_req.addr == `DLB_ADDR_ACQ_BW;
    endsequence

    sequence s_rd_damp;
        ce && reg_req.rd && reg_req.addr == `DLB_ADDR_AUX_DAMP;
    endsequence

    property p_acq_write_readback;
        @(posedge core_clk) disable iff (!rst_n)
        s_wr_acq ##1 s_rd_acq
        |=> reg_rdata == {`DLB_NIBBLE_ZERO,
                          $past(reg_req.wdata[`DLB_ACQ_BW_MSB:`DLB_ACQ_BW_LSB], 2)};
    endproperty
    a_acq_write_readback: assert property (p_acq_write_readback) else $error("acq readback"); // see R1

    property p_code_70hz;
        @(posedge core_clk) disable iff (!rst_n)
        ce && acq_bw_auto_en && !main_loop_locked && main_loop_acquire_bandwidth == `DLB_BW_70
        |=> main_cfg.bw_hzx10 == `DLB_HZX10_70;
    endproperty
    a_code_70hz: assert property (p_code_70hz) else $error("code 0001 not 70 Hz"); // see R3

    property p_code_18hz;
        @(posedge core_clk) disable iff (!rst_n)
        ce && acq_bw_auto_en && !main_loop_locked && main_loop_acquire_bandwidth == `DLB_BW_18
        |=> main_cfg.bw_hzx10 == `DLB_HZX10_18;
    endproperty
    a_code_18hz: assert property (p_code_18hz) else $error("code 1110 not 18 Hz"); // see R2

    property p_reserved_flag;
        @(posedge core_clk) disable iff (!rst_n)
        ce && main_loop_acquire_bandwidth[`DLB_ACQ_BW_MSB] == 1'b0
           && main_loop_acquire_bandwidth != `DLB_BW_70 |=> !acq_code_valid;
    endproperty
    a_reserved_flag: assert property (p_reserved_flag) else $error("reserved code valid"); // see R4

    property p_auto_switch;
        @(posedge core_clk) disable iff (!rst_n)
        ce && acq_bw_auto_en && !main_loop_locked
        |=> main_cfg.acq_in_use && main_cfg.bw_code == $past(main_loop_acquire_bandwidth);
    endproperty
    a_auto_switch: assert property (p_auto_switch) else $error("acq bw not switched in"); // see R5

    property p_acq_unused;
        @(posedge core_clk) disable iff (!rst_n)
        ce && (!acq_bw_auto_en || main_loop_locked)
        |=> !main_cfg.acq_in_use && main_cfg.bw_code == $past(main_locked_bw_code);
    endproperty
    a_acq_unused: assert property (p_acq_unused) else $error("acq bw used wrongly"); // see R5

    property p_gain_apply;
        @(posedge core_clk) disable iff (!rst_n)
        ce && aux_gain_sel_en && aux_ref_low_rate && aux_analog_feedback
        |=> aux_cfg.gain_apply && aux_cfg.gain == $past(aux_loop_detector2_low_rate_gain);
    endproperty
    a_gain_apply: assert property (p_gain_apply) else $error("detector 2 gain not applied"); // see R6

    property p_gain_ignored;
        @(posedge core_clk) disable iff (!rst_n)
        ce && !aux_gain_sel_en |=> aux_cfg.gain == `DLB_GAIN_OFF && !aux_cfg.gain_apply;
    endproperty
    a_gain_ignored: assert property (p_gain_ignored) else $error("detector 2 gain not ignored"); // see R7

    property p_damp_read;
        @(posedge core_clk) disable iff (!rst_n)
        s_rd_damp |=> reg_rvalid
                      && (reg_rdata & ~`DLB_MASK_AUX_DAMP) == `DLB_BYTE_ZERO
                      && reg_rdata[`DLB_DAMP_MSB:`DLB_DAMP_LSB] == aux_cfg.damping;
    endproperty
    a_damp_read: assert property (p_damp_read) else $error("damping readback"); // see R9

endmodule

`default_nettype wire

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none

module testbench
    import dlb_pkg::*;
;
    // Clock, reset and counters
    logic           core_clk            = 1'b0;
    logic           rst_n               = 1'b0;
    logic           ce                  = 1'b1;
    int             mismatches          = 0;
    int             compares            = 0;
    int             cycles              = 0;
    // Design inputs
    dlb_reg_req_s   reg_req             = '0;
    logic           acq_bw_auto_en      = 1'b0;
    logic           aux_gain_sel_en     = 1'b0;
    dlb_bw_code_t   main_locked_bw_code = 4'hD;
    logic           main_loop_locked    = 1'b0;
    logic           aux_ref_low_rate    = 1'b0;
    logic           aux_analog_feedback = 1'b0;
    // Design outputs
    logic [7:0]     reg_rdata;
    logic           reg_rvalid;
    dlb_main_cfg_s  main_cfg;
    logic           acq_code_valid;
    dlb_aux_cfg_s   aux_cfg;
    // Defined codes and their bandwidths in tenths of a hertz
    logic [3:0]     codes [9]           = '{4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF, 4'h1};
    logic [9:0]     hzx10 [9]           = '{10'h003, 10'h006, 10'h00C, 10'h019, 10'h028,
                                            10'h050, 10'h0B4, 10'h15E, 10'h2BC};

    dlb_loop_cfg dut_u (
        .core_clk            (core_clk),
        .rst_n               (rst_n),
        .ce                  (ce),
        .reg_req             (reg_req),
        .reg_rdata           (reg_rdata),
        .reg_rvalid          (reg_rvalid),
        .acq_bw_auto_en      (acq_bw_auto_en),
        .aux_gain_sel_en     (aux_gain_sel_en),
        .main_locked_bw_code (main_locked_bw_code),
        .main_loop_locked    (main_loop_locked),
        .aux_ref_low_rate    (aux_ref_low_rate),
        .aux_analog_feedback (aux_analog_feedback),
        .main_cfg            (main_cfg),
        .acq_code_valid      (acq_code_valid),
        .aux_cfg             (aux_cfg)
    );

    always #20 core_clk = ~core_clk;

    task automatic tally_and_finish();
        if (mismatches == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Whole run is about a hundred cycles; the ceiling leaves wide margin
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            mismatches++;
            tally_and_finish();
        end
    end

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Request held for one edge, then released
    task automatic bus_write(input logic [6:0] addr, input logic [7:0] data);
        @(posedge core_clk);
        reg_req <= '{addr: addr, wr: 1'b1, rd: 1'b0, wdata: data};
        @(posedge core_clk);
        reg_req <= '0;
    endtask

    task automatic bus_read(input logic [6:0] addr, input logic [7:0] exp);
        @(posedge core_clk);
        reg_req <= '{addr: addr, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        @(posedge core_clk);
        reg_req <= '0;
        #1;
        check("reg_rvalid", 16'h0001, {15'h0000, reg_rvalid});
        check("reg_rdata", {8'h00, exp}, {8'h00, reg_rdata});
    endtask

    // Write, then read on the very next edge; valid must drop after one cycle
    task automatic write_read(input logic [6:0] addr, input logic [7:0] data,
                              input logic [7:0] exp);
        @(posedge core_clk);
        reg_req <= '{addr: addr, wr: 1'b1, rd: 1'b0, wdata: data};
        @(posedge core_clk);
        reg_req <= '{addr: addr, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        @(posedge core_clk);
        reg_req <= '0;
        #1;
        check("reg_rvalid", 16'h0001, {15'h0000, reg_rvalid});
        check("reg_rdata", {8'h00, exp}, {8'h00, reg_rdata});
        @(posedge core_clk);
        #1;
        check("reg_rvalid", 16'h0000, {15'h0000, reg_rvalid});
    endtask

    // One cycle latency plus margin for the launching edge
    task automatic settle();
        repeat (2) @(posedge core_clk);
        #1;
    endtask

    task automatic check_main(input logic [3:0] code, input logic [9:0] hz, input logic use_acq);
        check("main_cfg", {1'b0, code, hz, use_acq}, {1'b0, main_cfg});
    endtask

    task automatic check_aux(input logic [2:0] damp, input logic [2:0] gain, input logic app);
        check("aux_cfg", {9'h000, damp, gain, app}, {9'h000, aux_cfg});
    endtask

    initial begin
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        settle();
        check_main(4'hD, 10'h000, 1'b0);
        check("acq_code_valid", 16'h0001, {15'h0000, acq_code_valid});
        check_aux(3'h3, 3'h0, 1'b0);
        bus_read(7'h69, 8'h0F);
        bus_read(7'h6A, 8'h13);
        bus_read(7'h10, 8'h00);
        // Unlocked with automatic switching: acquisition code drives the loop
        @(posedge core_clk);
        acq_bw_auto_en <= 1'b1;
        for (int i = 0; i < 9; i++) begin
            bus_write(7'h69, {4'h0, codes[i]});
            settle();
            check_main(codes[i], hzx10[i], 1'b1);
            check("acq_code_valid", 16'h0001, {15'h0000, acq_code_valid});
        end
        // Reserved codes are stored but flagged
        bus_write(7'h69, 8'h02);
        settle();
        check("acq_code_valid", 16'h0000, {15'h0000, acq_code_valid});
        check("bw_hzx10", 16'h0000, {6'h00, main_cfg.bw_hzx10});
        bus_write(7'h69, 8'h00);
        settle();
        check("acq_code_valid", 16'h0000, {15'h0000, acq_code_valid});
        // Upper nibble is not stored
        write_read(7'h69, 8'hF1, 8'h01);
        @(posedge core_clk);
        main_loop_locked <= 1'b1;
        settle();
        check_main(4'hD, 10'h000, 1'b0);
        @(posedge core_clk);
        main_loop_locked <= 1'b0;
        acq_bw_auto_en <= 1'b0;
        settle();
        check_main(4'hD, 10'h000, 1'b0);
        // Frozen clock enable must drop a write
        @(posedge core_clk);
        ce <= 1'b0;
        bus_write(7'h69, 8'h08);
        @(posedge core_clk);
        ce <= 1'b1;
        bus_read(7'h69, 8'h01);
        // Auxiliary damping and detector gain
        bus_write(7'h6A, 8'hFF);
        bus_read(7'h6A, 8'h77);
        settle();
        check_aux(3'h7, 3'h0, 1'b0);
        @(posedge core_clk);
        aux_gain_sel_en <= 1'b1;
        aux_ref_low_rate <= 1'b1;
        settle();
        check_aux(3'h7, 3'h7, 1'b0);
        @(posedge core_clk);
        aux_analog_feedback <= 1'b1;
        settle();
        check_aux(3'h7, 3'h7, 1'b1);
        bus_write(7'h6A, 8'h25);
        settle();
        check_aux(3'h5, 3'h2, 1'b1);
        @(posedge core_clk);
        aux_gain_sel_en <= 1'b0;
        settle();
        check_aux(3'h5, 3'h0, 1'b0);
        tally_and_finish();
    end
endmodule

`default_nettype wire
